/* pkg/obcd_pkg.sv */
// constants for the configuration byte decoder
package obcd_pkg;
    // register byte offsets on the avalon slave
    localparam logic [3:0] OFS_CFG_BYTE_ZERO = 4'h0;
    localparam logic [3:0] OFS_CFG_BYTE_ONE  = 4'h4;
    localparam logic [3:0] OFS_STATUS        = 4'h8;
    localparam logic [3:0] OFS_CONTROL       = 4'hC;

    // reset values of the two configuration bytes
    localparam logic [7:0] RST_CFG_BYTE_ZERO = 8'hFC;
    localparam logic [7:0] RST_CFG_BYTE_ONE  = 8'hEF;

    // field positions in configuration byte one
    localparam int POS_PLL_MULT   = 7;
    localparam int POS_PLL_BYPASS = 6;
    localparam int POS_RESERVED   = 5;
    localparam int POS_RC_DISABLE = 4;
    localparam int POS_VTH_HI     = 3;
    localparam int POS_VTH_LO     = 2;
    localparam int POS_WDG_SELECT = 1;
    localparam int POS_HALT_RESET = 0;

    // voltage threshold field encodings
    localparam logic [1:0] VTH_OFF    = 2'h3;
    localparam logic [1:0] VTH_HIGH   = 2'h2;
    localparam logic [1:0] VTH_MEDIUM = 2'h1;
    localparam logic [1:0] VTH_LOW    = 2'h0;

    // status register bits
    localparam int POS_ST_LOADED    = 0;
    localparam int POS_ST_RSV_ERROR = 1;
    localparam int POS_ST_WDG_ON    = 2;
    localparam int POS_ST_HALT_SEEN = 3;

    // control register bits
    localparam int POS_CT_WDG_SW_EN  = 0;
    localparam int POS_CT_HALT_CLEAR = 1;

    // non-volatile storage addresses of the two bytes
    localparam logic [7:0] NV_ADDR_BYTE_ZERO = 8'h00;
    localparam logic [7:0] NV_ADDR_BYTE_ONE  = 8'h01;

    // loader sequence, one-hot
    typedef enum logic [3:0] {
        LD_REQ0 = 4'h1,
        LD_REQ1 = 4'h2,
        LD_CAP1 = 4'h4,
        LD_DONE = 4'h8
    } obcd_ld_state_t;
endpackage

/* pkg/obcd_cfg_if.sv */
// bundle carrying the loaded configuration bytes
`timescale 1ns/10ps
`default_nettype none
interface obcd_cfg_if;
    logic [7:0] byte_zero;
    logic [7:0] byte_one;
    logic       loaded;
    modport load (output byte_zero, output byte_one, output loaded);
    modport use_side (input byte_zero, input byte_one, input loaded);
endinterface
`default_nettype wire

/* verilog/obcd_loader.sv */
// loader fetching both configuration bytes from storage after reset
`timescale 1ns/10ps
`default_nettype none
module obcd_loader
    import obcd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    output logic            nv_rd_o,
    output logic [7:0]      nv_addr_o,
    input  wire logic [7:0] nv_data_i,
    obcd_cfg_if.load        cfg
);
    obcd_ld_state_t state;

    // sequence: address byte 0, capture it and address byte 1, capture
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= LD_REQ0;
        else
        begin
            case (state)
                LD_REQ0: state <= LD_REQ1;
                LD_REQ1: state <= LD_CAP1;
                LD_CAP1: state <= LD_DONE;
                LD_DONE: state <= LD_DONE;
                default: state <= LD_REQ0;
            endcase
        end
    end

    // storage answers one cycle after the address
    always_comb
    begin
        nv_rd_o   = (state == LD_REQ0) || (state == LD_REQ1);
        nv_addr_o = (state == LD_REQ1) ? NV_ADDR_BYTE_ONE
                                       : NV_ADDR_BYTE_ZERO;
    end

    // bytes take only the reload, then freeze until the next reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg.byte_zero <= RST_CFG_BYTE_ZERO;
            cfg.byte_one  <= RST_CFG_BYTE_ONE;
            cfg.loaded    <= 1'b0;
        end
        else
        begin
            if (state == LD_REQ1)
                cfg.byte_zero <= nv_data_i;
            if (state == LD_CAP1)
            begin
                cfg.byte_one <= nv_data_i;
                cfg.loaded   <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/obcd_top.sv */
// configuration byte decoder with avalon register slave
//
// Notes on behaviour
// - pll factor bit: 0 times four, 1 eight
// - bypass bit 0 enables pll, 1 bypasses
// - oscillator bit 0 rc on, 1 off
// - threshold field: 11 off, 10/01/00 high-med-low
// - watchdog bit 0 hardware, 1 software enabled
// - halt-reset bit 1 resets on halt entry
`timescale 1ns/10ps
`default_nettype none
module obcd_top
    import obcd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // non-volatile storage read port
    output logic             nv_rd_o,
    output logic [7:0]       nv_addr_o,
    input  wire logic [7:0]  nv_data_i,
    // halt entry strobe from the core
    input  wire logic        halt_entry_i,
    // decoded settings
    output logic             settings_valid_o,
    output logic             pll_mult_eight_o,
    output logic             pll_enable_o,
    output logic             pll_bypass_o,
    output logic             rc_osc_enable_o,
    output logic             voltage_detect_enable_o,
    output logic             supply_warning_enable_o,
    output logic [2:0]       voltage_threshold_select_o,
    output logic             watchdog_hw_mode_o,
    output logic             watchdog_enable_o,
    output logic             halt_reset_o
);
    obcd_cfg_if cfg ();

    logic       ack;
    logic       bus_req;
    logic       wdg_sw_en;
    logic       halt_seen;
    logic       rsv_error;
    logic [7:0] opt;

    // one-hot threshold: bit2 high, bit1 medium, bit0 lowest; 0 off
    function automatic logic [2:0] vth_decode(input logic [1:0] f);
        logic [2:0] r;
        r = 3'h0;
        case (f)
            VTH_HIGH:   r = 3'h4;
            VTH_MEDIUM: r = 3'h2;
            VTH_LOW:    r = 3'h1;
            default:    r = 3'h0;
        endcase
        return r;
    endfunction

    // register index from byte address
    function automatic logic is_reg(input logic [3:0] a,
                                    input logic [3:0] ofs);
        return a[3:2] == ofs[3:2];
    endfunction

    obcd_loader u_loader (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .nv_rd_o   (nv_rd_o),
        .nv_addr_o (nv_addr_o),
        .nv_data_i (nv_data_i),
        .cfg       (cfg)
    );

    assign opt = cfg.byte_one;

    // decoded settings, registered; static once the load completes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            settings_valid_o           <= 1'b0;
            pll_mult_eight_o           <= RST_CFG_BYTE_ONE[POS_PLL_MULT];
            pll_bypass_o               <= RST_CFG_BYTE_ONE[POS_PLL_BYPASS];
            pll_enable_o               <= ~RST_CFG_BYTE_ONE[POS_PLL_BYPASS];
            rc_osc_enable_o            <= ~RST_CFG_BYTE_ONE[POS_RC_DISABLE];
            voltage_detect_enable_o    <= 1'b0;
            supply_warning_enable_o    <= 1'b0;
            voltage_threshold_select_o <= 3'h0;
            watchdog_hw_mode_o         <= 1'b0;
        end
        else
        begin
            settings_valid_o           <= cfg.loaded;
            pll_mult_eight_o           <= opt[POS_PLL_MULT];
            pll_bypass_o               <= opt[POS_PLL_BYPASS];
            pll_enable_o               <= ~opt[POS_PLL_BYPASS];
            rc_osc_enable_o            <= ~opt[POS_RC_DISABLE];
            voltage_detect_enable_o    <=
                opt[POS_VTH_HI:POS_VTH_LO] != VTH_OFF;
            supply_warning_enable_o    <=
                opt[POS_VTH_HI:POS_VTH_LO] != VTH_OFF;
            voltage_threshold_select_o <=
                vth_decode(opt[POS_VTH_HI:POS_VTH_LO]);
            // hardware mode only once a real byte is in
            watchdog_hw_mode_o <= cfg.loaded & ~opt[POS_WDG_SELECT];
        end
    end

    // watchdog runs in hardware mode or once software enables it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            watchdog_enable_o <= 1'b0;
        else
            watchdog_enable_o <= cfg.loaded &
                (~opt[POS_WDG_SELECT] | wdg_sw_en);
    end

    // reset request on halt entry; suppressed before the load ends
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            halt_reset_o <= 1'b0;
        else
            halt_reset_o <= halt_entry_i & cfg.loaded &
                            opt[POS_HALT_RESET];
    end

    // avalon handshake: one wait cycle, answer in the second
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack <= 1'b0;
        else
            ack <= bus_req & ~ack;
    end

    // software enable is set-only: the watchdog cannot be stopped
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wdg_sw_en <= 1'b0;
        else if (avs_write && ack && avs_byteenable[0]
                 && is_reg(avs_address, OFS_CONTROL)
                 && avs_writedata[POS_CT_WDG_SW_EN])
            wdg_sw_en <= 1'b1;
    end

    // sticky halt-reset record; a new event beats the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            halt_seen <= 1'b0;
        else if (halt_reset_o)
            halt_seen <= 1'b1;
        else if (avs_write && ack && avs_byteenable[0]
                 && is_reg(avs_address, OFS_CONTROL)
                 && avs_writedata[POS_CT_HALT_CLEAR])
            halt_seen <= 1'b0;
    end

    // programmer must leave the reserved bit set; flag it if not
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rsv_error <= 1'b0;
        else
            rsv_error <= cfg.loaded & ~opt[POS_RESERVED];
    end

    // read data captured in the wait cycle; every other address reads the control register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            avs_readdata <= 32'h0;
        else if (avs_read && !ack)
        begin
            avs_readdata <= 32'h0;
            if (is_reg(avs_address, OFS_CFG_BYTE_ZERO))
                avs_readdata <= {24'h0, cfg.byte_zero};
            else if (is_reg(avs_address, OFS_CFG_BYTE_ONE))
                avs_readdata <= {24'h0, cfg.byte_one};
            else if (is_reg(avs_address, OFS_STATUS))
                avs_readdata <= {28'h0, halt_seen, watchdog_enable_o,
                                 rsv_error, cfg.loaded};
            else
                avs_readdata <= {30'h0, 1'b0, wdg_sw_en};
        end
    end

    // ---- checks on the decoded settings, the held configuration bytes and the load time
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_pll_factor;
        $past(cfg.loaded) |->
            pll_mult_eight_o == $past(opt[POS_PLL_MULT]);
    endproperty
    a_pll_factor: assert property (p_pll_factor)
        else $error("pll factor differs from byte");

    property p_pll_bypass;
        $past(cfg.loaded) |->
            (pll_enable_o != pll_bypass_o)
            && (pll_bypass_o == $past(opt[POS_PLL_BYPASS]));
    endproperty
    a_pll_bypass: assert property (p_pll_bypass)
        else $error("pll enable and bypass disagree");

    property p_rc_osc;
        $past(cfg.loaded) |->
            rc_osc_enable_o == !$past(opt[POS_RC_DISABLE]);
    endproperty
    a_rc_osc: assert property (p_rc_osc)
        else $error("rc oscillator state wrong");

    property p_vth_off;
        $past(cfg.loaded)
        && $past(opt[POS_VTH_HI:POS_VTH_LO]) == VTH_OFF |->
            !voltage_detect_enable_o && !supply_warning_enable_o
            && voltage_threshold_select_o == 3'h0;
    endproperty
    a_vth_off: assert property (p_vth_off)
        else $error("detectors on with field off");

    property p_vth_on;
        $past(cfg.loaded)
        && $past(opt[POS_VTH_HI:POS_VTH_LO]) == VTH_HIGH |->
            voltage_detect_enable_o && supply_warning_enable_o
            && voltage_threshold_select_o == 3'h4;
    endproperty
    a_vth_on: assert property (p_vth_on)
        else $error("high threshold not selected");

    property p_wdg_mode;
        cfg.loaded && !opt[POS_WDG_SELECT] |=> ##1
            watchdog_enable_o [*3];
    endproperty
    a_wdg_mode: assert property (p_wdg_mode)
        else $error("hardware watchdog not running");

    property p_wdg_sw;
        $past(cfg.loaded) && $past(opt[POS_WDG_SELECT])
        && !$past(wdg_sw_en) |-> !watchdog_enable_o;
    endproperty
    a_wdg_sw: assert property (p_wdg_sw)
        else $error("software watchdog ran unenabled");

    property p_halt_reset;
        halt_entry_i && cfg.loaded |=>
            halt_reset_o == $past(opt[POS_HALT_RESET]);
    endproperty
    a_halt_reset: assert property (p_halt_reset)
        else $error("halt reset does not follow bit");

    property p_held;
        cfg.loaded |=> cfg.loaded && $stable(cfg.byte_one)
                       && $stable(cfg.byte_zero);
    endproperty
    a_held: assert property (p_held)
        else $error("configuration changed after load");

    property p_load_time;
        $fell(rst_i) |-> ##3 cfg.loaded ##1 settings_valid_o;
    endproperty
    a_load_time: assert property (p_load_time)
        else $error("load not complete four cycles after reset");
endmodule
`default_nettype wire

/* verification/obcd_top_tb_top.sv */
// self-checking testbench for the configuration byte decoder
`timescale 1ns/10ps
`default_nettype none
module obcd_top_tb_top;
    import obcd_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        nv_rd_o;
    logic [7:0]  nv_addr_o;
    logic [7:0]  nv_data_i = 8'h00;
    logic        halt_entry_i = 1'b0;
    logic        settings_valid_o;
    logic        halt_reset_o;
    logic [10:0] dec_out;
    logic [7:0]  nvm0 = 8'hFC;
    logic [7:0]  nvm1 = 8'hEF;
    // every entry keeps the reserved bit 5 set
    logic [7:0]  tbl [4] = '{8'hEF, 8'h3B, 8'hA4, 8'h70};
    int          errors = 0;
    int          compares = 0;

    obcd_top u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .nv_rd_o(nv_rd_o),
        .nv_addr_o(nv_addr_o), .nv_data_i(nv_data_i),
        .halt_entry_i(halt_entry_i), .settings_valid_o(settings_valid_o),
        .pll_mult_eight_o(dec_out[10]), .pll_enable_o(dec_out[9]),
        .pll_bypass_o(dec_out[8]), .rc_osc_enable_o(dec_out[7]),
        .voltage_detect_enable_o(dec_out[6]),
        .supply_warning_enable_o(dec_out[5]),
        .voltage_threshold_select_o(dec_out[4:2]),
        .watchdog_hw_mode_o(dec_out[1]), .watchdog_enable_o(dec_out[0]),
        .halt_reset_o(halt_reset_o));

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    // storage answers one cycle after the address; scrambles when idle
    always @(posedge clk_i)
    begin
        if (nv_rd_o === 1'b1)
            nv_data_i <= (nv_addr_o == NV_ADDR_BYTE_ONE) ? nvm1 : nvm0;
        else
            nv_data_i <= ~nv_data_i;
    end

    // expected decode, independent of the design
    function automatic logic [10:0] dec(input logic [7:0] b);
        logic [2:0] th;
        case (b[3:2])
            2'h3: th = 3'h0;
            2'h2: th = 3'h4;
            2'h1: th = 3'h2;
            default: th = 3'h1;
        endcase
        dec = {b[7], ~b[6], b[6], ~b[4], b[3:2] != 2'h3,
               b[3:2] != 2'h3, th, ~b[1], ~b[1]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one avalon transfer; holds until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        @(posedge clk_i);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= ~wr;
        avs_write      <= wr;
        do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // reset, then wait for the load with a bounded count
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk({31'h0, settings_valid_o}, 32'h0);
        rst_i <= 1'b0;
        repeat (20)
        begin
            @(posedge clk_i);
            if (settings_valid_o === 1'b1)
                break;
        end
        @(negedge clk_i);
        chk({31'h0, settings_valid_o}, 32'h1);
    endtask

    // decode of every field except halt-reset, stored bytes, hold after storage changes
    task automatic t_decode(input logic [7:0] b1);
        logic [31:0] q;
        nvm1 = b1;
        nvm0 = ~b1;
        do_reset();
        chk({21'h0, dec_out}, {21'h0, dec(b1)});
        bus(1'b0, OFS_CFG_BYTE_ONE, 32'h0, 4'hF, q);
        chk(q, {24'h0, b1});
        bus(1'b0, OFS_CFG_BYTE_ZERO, 32'h0, 4'hF, q);
        chk(q, {24'h0, ~b1});
        nvm1 = ~b1;
        bus(1'b1, OFS_CFG_BYTE_ONE, 32'hFF, 4'hF, q);
        bus(1'b0, OFS_CFG_BYTE_ONE, 32'h0, 4'hF, q);
        chk(q, {24'h0, b1});
        chk({21'h0, dec_out}, {21'h0, dec(b1)});
        $display("decode test done for %h", b1);
    endtask

    // halt entry gives a reset pulse only when enabled
    task automatic t_halt(input logic [7:0] b1);
        logic [31:0] q;
        @(posedge clk_i);
        halt_entry_i <= 1'b1;
        @(posedge clk_i);
        halt_entry_i <= 1'b0;
        @(negedge clk_i);
        chk({31'h0, halt_reset_o}, {31'h0, b1[0]});
        @(negedge clk_i);
        chk({31'h0, halt_reset_o}, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
        chk({28'h0, q[3:0]}, {28'h0, b1[0], ~b1[1], ~b1[5], 1'b1});
        bus(1'b1, OFS_CONTROL, 32'h2, 4'h1, q);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
        chk({31'h0, q[3]}, 32'h0);
        $display("halt test done for %h", b1);
    endtask

    // software watchdog stays off until enabled; hardware is always on
    task automatic t_wdg(input logic [7:0] b1);
        logic [31:0] q;
        bus(1'b1, OFS_CONTROL, 32'h1, 4'h0, q);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
        chk({31'h0, q[2]}, {31'h0, ~b1[1]});
        chk({31'h0, dec_out[0]}, {31'h0, ~b1[1]});
        bus(1'b1, OFS_CONTROL, 32'h1, 4'h1, q);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
        chk({31'h0, q[2]}, 32'h1);
        chk({31'h0, dec_out[1]}, {31'h0, ~b1[1]});
        bus(1'b0, OFS_CONTROL, 32'h0, 4'hF, q);
        chk(q, 32'h1);
        $display("watchdog test done for %h", b1);
    endtask

    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // main sequence over all table entries
    initial
    begin
        foreach (tbl[i])
        begin
            t_decode(tbl[i]);
            t_halt(tbl[i]);
            t_wdg(tbl[i]);
        end
        test_done();
    end

    // watchdog: runs well past the expected few hundred cycles
    initial
    begin
        #200000;
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
